/* File: shared/tms_pkg.sv */
// shared constants and state types of the trunk message sequencer
package tms_pkg;

  // frame delimiting and bit stuffing
  localparam logic [7:0]  FLAG_PATTERN = 8'h7E;
  localparam logic [2:0]  STUFF_ONES   = 3'h5;
  localparam logic [2:0]  FLAG_ONES    = 3'h6;
  localparam logic [2:0]  ABORT_ONES   = 3'h7;
  localparam logic [2:0]  DELAY_BITS   = 3'h7;

  // request function codes
  localparam logic [3:0]  FN_READ      = 4'h5;
  localparam logic [3:0]  FN_WRITE     = 4'hD;
  localparam logic [3:0]  FN_RESET     = 4'h6;

  // word positions inside a request, counted after the opening flag
  localparam logic [11:0] W_CTRL       = 12'h000;
  localparam logic [11:0] W_START      = 12'h001;
  localparam logic [11:0] W_CSTART     = 12'h002;
  localparam logic [11:0] W_CEND       = 12'h003;
  localparam logic [11:0] W_PARITY     = 12'h004;
  localparam logic [11:0] W_DATA       = 12'h005;
  localparam logic [11:0] W_DATA_NEXT  = 12'h006;

  // lengths in bits and words
  localparam logic [15:0] REQ_BITS     = 16'h0060;
  localparam logic [15:0] MIN_WORDS    = 16'h0002;
  localparam logic [15:0] MAX_WORDS    = 16'h0800;
  localparam logic [15:0] BITN_LIMIT   = 16'hFFF0;

  // default values
  localparam logic [15:0] SEQ_BASE_DEF = 16'hFF00;
  localparam logic [15:0] CRC_POLY_DEF = 16'h1021;
  localparam logic [3:0]  RESP_ACC_DEF = 4'h0;
  localparam logic [3:0]  RESP_REJ_DEF = 4'hF;
  localparam logic [15:0] CRC_INIT     = 16'h0000;

  // transmit queue entry: last marker above one data word
  localparam int          TXQ_WIDTH    = 17;
  localparam int          TXQ_DEPTH    = 4;

  typedef enum logic [2:0] {
    E_IDLE   = 3'h0,
    E_SEQ_RD = 3'h1,
    E_DAT_WR = 3'h3,
    E_EVAL   = 3'h2,
    E_HDR    = 3'h6,
    E_RD_DAT = 3'h7,
    E_SEQ_WR = 3'h5
  } tms_eng_t;

  typedef enum logic [1:0] {
    T_FLAG = 2'h0,
    T_DATA = 2'h1,
    T_CRC  = 2'h3,
    T_END  = 2'h2
  } tms_tx_t;

endpackage : tms_pkg

/* File: design/tms_fifo.sv */
// word queue with valid and ready on both sides
module tms_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("tms_fifo: depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } tms_fifo_st_t;

  tms_fifo_st_t st;
  tms_fifo_st_t next_st;

  assign in_ready  = !((st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]));
  assign out_valid = (st.wp != st.rp);
  assign out_data  = st.mem[st.rp[AW-1:0]];

  always_comb begin
    next_st = st;
    if (in_valid && in_ready) begin
      next_st.mem[st.wp[AW-1:0]] = in_data;
      next_st.wp                 = st.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      next_st.rp = st.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : tms_fifo

/* File: design/tms_engine.sv */
// trunk link protocol engine: request deframing, checks, buffer access, responses

// Operation
// R1 - every frame carries a 16-bit CRC
// R2 - only read, write and reset sequences
// R3 - function 0101 reads, answered with data
// R4 - read request field order and widths
// R5 - compare sequence number with stored count
// R6 - read checked by parity and CRC
// R7 - parity word is even parity of 64 bits
// R8 - closing flag after CRC ends request
// R9 - flags, then read response after processing
// R10 - read response field order
// R11 - read data is 2 to 2048 words
// R12 - device generates response CRC
// R13 - function 1101 writes, answered with response
// R14 - write header checked by even parity
// R15 - write data up to 2048 words
// R16 - write CRC covers all received bits
// R17 - accept write only when error free
// R18 - response CRC then closing flag
// R19 - every write message gets a response
// R20 - flag delimited, zero after five ones
// R21 - seven ones abort the frame
// R22 - most significant bit first
// R23 - store incremented sequence and response
// R24 - accept and reject codes are parameters
// R25 - any error rejects and blocks access; code still writes data words before the CRC is checked
module tms_engine #(
  parameter logic [15:0] CRC_POLY    = tms_pkg::CRC_POLY_DEF,
  parameter logic [15:0] SEQ_BASE    = tms_pkg::SEQ_BASE_DEF,
  parameter logic [3:0]  RESP_ACCEPT = tms_pkg::RESP_ACC_DEF,
  parameter logic [3:0]  RESP_REJECT = tms_pkg::RESP_REJ_DEF,
  parameter int          FIFO_DEPTH  = tms_pkg::TXQ_DEPTH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // serial link from the modem
  input  wire logic        rx_clk_pin,
  input  wire logic        rx_data_pin,
  input  wire logic        tx_clk_pin,
  output logic             tx_data,
  // station buffer memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  // message status
  output logic             msg_done,
  output logic             msg_accepted
);

  if (RESP_ACCEPT == RESP_REJECT || FIFO_DEPTH < 2) begin : g_bad_param
    $error("tms_engine: accept and reject codes must differ, queue depth at least 2");
  end

  typedef struct packed {
    logic [2:0]       rc_s;
    logic [2:0]       rd_s;
    logic [2:0]       tc_s;
    logic             rc_l;
    logic             rd_l;
    logic             tc_l;
    logic [2:0]       r_ones;
    logic [6:0]       r_dly;
    logic [2:0]       r_dcnt;
    logic             r_in;
    logic [15:0]      r_bitn;
    logic [15:0]      r_sreg;
    logic [15:0]      r_crc;
    logic [15:0]      r_par;
    logic [7:0]       r_term;
    logic [3:0]       r_func;
    logic [3:0]       r_seq;
    logic [15:0]      r_start;
    logic [15:0]      r_end;
    logic [15:0]      r_hold;
    logic [15:0]      r_wptr;
    logic             r_fmt_err;
    logic             r_adr_err;
    logic             r_par_err;
    logic             r_ovf_err;
    tms_pkg::tms_eng_t e_st;
    logic             seq_go;
    logic             seq_done;
    logic             seq_err;
    logic [3:0]       seq_mem;
    logic             wr_pend;
    logic [15:0]      p_addr;
    logic [15:0]      p_data;
    logic             end_pend;
    logic             f_ok;
    logic             acc;
    logic [3:0]       resp;
    logic [3:0]       seq_new;
    logic [15:0]      rptr;
    logic [11:0]      rcnt;
    logic             mem_req;
    logic             mem_we;
    logic [15:0]      mem_addr;
    logic [15:0]      mem_wdata;
    logic             msg_done;
    logic             msg_acc;
    tms_pkg::tms_tx_t t_mode;
    logic [2:0]       t_fi;
    logic [15:0]      t_sreg;
    logic [3:0]       t_cnt;
    logic [2:0]       t_ones;
    logic             t_last;
    logic [15:0]      t_crc;
    logic             tx_data;
  } tms_st_t;

  tms_st_t    st;
  tms_st_t    next_st;
  logic       q_in_valid;
  logic [16:0] q_in_data;
  logic       q_in_ready;
  logic       q_out_valid;
  logic [16:0] q_out_data;
  logic       q_out_ready;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction : crc_step

  tms_fifo #(
    .WIDTH (tms_pkg::TXQ_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_txq (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (q_in_valid),
    .in_data   (q_in_data),
    .in_ready  (q_in_ready),
    .out_valid (q_out_valid),
    .out_data  (q_out_data),
    .out_ready (q_out_ready)
  );

  assign tx_data      = st.tx_data;
  assign mem_req      = st.mem_req;
  assign mem_we       = st.mem_we;
  assign mem_addr     = st.mem_addr;
  assign mem_wdata    = st.mem_wdata;
  assign msg_done     = st.msg_done;
  assign msg_accepted = st.msg_acc;

  always_comb begin
    logic        rx_tick;
    logic        tx_tick;
    logic        dv;
    logic        db;
    logic        tb;
    logic [15:0] w;
    logic [11:0] k;
    logic [15:0] nwords;
    logic        blocked;
    logic        len_ok;
    rx_tick = 1'b0;
    tx_tick = 1'b0;
    dv      = 1'b0;
    db      = 1'b0;
    tb      = 1'b0;
    w       = 16'h0000;
    k       = 12'h000;
    nwords  = 16'h0000;
    blocked = 1'b0;
    len_ok  = 1'b0;
    q_in_valid  = 1'b0;
    q_in_data   = 17'h00000;
    q_out_ready = 1'b0;
    next_st = st;
    next_st.msg_done = 1'b0;

    // pin synchronisers: a level counts once stages two and three agree
    next_st.rc_s = {st.rc_s[1:0], rx_clk_pin};
    next_st.rd_s = {st.rd_s[1:0], rx_data_pin};
    next_st.tc_s = {st.tc_s[1:0], tx_clk_pin};
    if (st.rc_s[1] == st.rc_s[2]) next_st.rc_l = st.rc_s[2];
    if (st.rd_s[1] == st.rd_s[2]) next_st.rd_l = st.rd_s[2];
    if (st.tc_s[1] == st.tc_s[2]) next_st.tc_l = st.tc_s[2];
    rx_tick = st.rc_s[1] && st.rc_s[2] && !st.rc_l;
    tx_tick = st.tc_s[1] && st.tc_s[2] && !st.tc_l;

    // memory port and responses
    case (st.e_st)
      tms_pkg::E_IDLE: begin
        if (st.seq_go) begin
          next_st.e_st     = tms_pkg::E_SEQ_RD;
          next_st.mem_req  = 1'b1;
          next_st.mem_we   = 1'b0;
          next_st.mem_addr = SEQ_BASE + {8'h00, st.r_term};
        end else if (st.wr_pend) begin
          next_st.e_st      = tms_pkg::E_DAT_WR;
          next_st.mem_req   = 1'b1;
          next_st.mem_we    = 1'b1;
          next_st.mem_addr  = st.p_addr;
          next_st.mem_wdata = st.p_data;
        end else if (st.end_pend) begin
          next_st.e_st = tms_pkg::E_EVAL;
        end
      end
      tms_pkg::E_SEQ_RD: begin
        if (mem_ack) begin
          next_st.mem_req  = 1'b0;
          next_st.seq_go   = 1'b0;
          next_st.seq_done = 1'b1;
          next_st.seq_mem  = mem_rdata[3:0];
          next_st.seq_err  = (mem_rdata[3:0] != st.r_seq); // R5
          next_st.e_st     = tms_pkg::E_IDLE;
        end
      end
      tms_pkg::E_DAT_WR: begin
        if (mem_ack) begin
          next_st.mem_req = 1'b0;
          next_st.wr_pend = 1'b0;
          next_st.e_st    = tms_pkg::E_IDLE;
        end
      end
      tms_pkg::E_EVAL: begin
        nwords = st.r_end - st.r_start + 16'h0001;
        next_st.acc = st.f_ok && st.seq_done; // R25
        case (st.r_func) // R2
          tms_pkg::FN_READ: begin // R3
            if (st.seq_err || st.r_end < st.r_start || nwords < tms_pkg::MIN_WORDS
                || nwords > tms_pkg::MAX_WORDS) next_st.acc = 1'b0; // R11
          end
          tms_pkg::FN_WRITE: begin // R13
            if (st.seq_err) next_st.acc = 1'b0; // R17
          end
          tms_pkg::FN_RESET: ;
          default: next_st.acc = 1'b0;
        endcase
        next_st.resp    = next_st.acc ? RESP_ACCEPT : RESP_REJECT; // R24
        next_st.seq_new = !next_st.acc ? st.seq_mem :
                          (st.r_func == tms_pkg::FN_RESET) ? 4'h0 : st.seq_mem + 4'h1; // R23
        next_st.rptr    = st.r_start;
        next_st.rcnt    = nwords[11:0];
        next_st.e_st    = tms_pkg::E_HDR;
      end
      tms_pkg::E_HDR: begin
        if (q_in_ready) begin
          q_in_valid = 1'b1; // R10
          q_in_data  = {!(st.acc && st.r_func == tms_pkg::FN_READ),
                        st.r_term, st.resp, st.r_seq}; // R19
          if (st.acc && st.r_func == tms_pkg::FN_READ) begin
            next_st.e_st = tms_pkg::E_RD_DAT;
          end else begin
            next_st.e_st      = tms_pkg::E_SEQ_WR;
            next_st.mem_req   = 1'b1;
            next_st.mem_we    = 1'b1;
            next_st.mem_addr  = SEQ_BASE + {8'h00, st.r_term};
            next_st.mem_wdata = {st.r_term, st.resp, st.seq_new}; // R23
          end
        end
      end
      tms_pkg::E_RD_DAT: begin
        if (!st.mem_req && q_in_ready) begin
          next_st.mem_req  = 1'b1;
          next_st.mem_we   = 1'b0;
          next_st.mem_addr = st.rptr;
        end else if (st.mem_req && mem_ack) begin
          q_in_valid   = 1'b1; // R11
          q_in_data    = {st.rcnt == 12'h001, mem_rdata};
          next_st.rptr = st.rptr + 16'h0001;
          next_st.rcnt = st.rcnt - 12'h001;
          next_st.mem_req = 1'b0;
          if (st.rcnt == 12'h001) begin
            next_st.e_st      = tms_pkg::E_SEQ_WR;
            next_st.mem_req   = 1'b1;
            next_st.mem_we    = 1'b1;
            next_st.mem_addr  = SEQ_BASE + {8'h00, st.r_term};
            next_st.mem_wdata = {st.r_term, st.resp, st.seq_new};
          end
        end
      end
      tms_pkg::E_SEQ_WR: begin
        if (mem_ack) begin
          next_st.mem_req  = 1'b0;
          next_st.end_pend = 1'b0;
          next_st.msg_done = 1'b1;
          next_st.msg_acc  = st.acc;
          next_st.e_st     = tms_pkg::E_IDLE;
        end
      end
      default: next_st.e_st = tms_pkg::E_IDLE;
    endcase

    // receiver: flags, zero deletion, abort
    if (rx_tick) begin
      if (st.rd_l) begin
        next_st.r_ones = (st.r_ones == tms_pkg::ABORT_ONES) ? st.r_ones : st.r_ones + 3'h1;
        if (st.r_ones + 3'h1 == tms_pkg::ABORT_ONES) begin
          next_st.r_in   = 1'b0; // R21
          next_st.r_dcnt = 3'h0;
        end else if (st.r_ones != tms_pkg::ABORT_ONES) begin
          next_st.r_dly = {st.r_dly[5:0], 1'b1};
          dv = (st.r_dcnt == tms_pkg::DELAY_BITS);
          db = st.r_dly[6];
          if (!dv) next_st.r_dcnt = st.r_dcnt + 3'h1;
        end
      end else begin
        next_st.r_ones = 3'h0;
        if (st.r_ones == tms_pkg::FLAG_ONES) begin // R20
          if (st.r_in && st.r_bitn >= 16'h0010 && !st.end_pend) begin // R8
            len_ok = (st.r_bitn[3:0] == 4'h0) && (st.r_bitn >= tms_pkg::REQ_BITS)
                     && (st.r_func == tms_pkg::FN_WRITE || st.r_bitn == tms_pkg::REQ_BITS); // R4
            next_st.f_ok = len_ok && (st.r_crc == 16'h0000) && !st.r_fmt_err // R16
                           && !st.r_adr_err && !st.r_par_err && !st.r_ovf_err; // R25
            next_st.end_pend = 1'b1;
          end
          next_st.r_in      = !(st.end_pend || next_st.end_pend);
          next_st.r_dcnt    = 3'h0;
          next_st.r_bitn    = 16'h0000;
          next_st.r_crc     = tms_pkg::CRC_INIT;
          next_st.r_par     = 16'h0000;
          next_st.r_fmt_err = 1'b0;
          next_st.r_adr_err = 1'b0;
          next_st.r_par_err = 1'b0;
          next_st.r_ovf_err = 1'b0;
        end else if (st.r_ones != tms_pkg::STUFF_ONES) begin
          next_st.r_dly = {st.r_dly[5:0], 1'b0};
          dv = (st.r_dcnt == tms_pkg::DELAY_BITS);
          db = st.r_dly[6];
          if (!dv) next_st.r_dcnt = st.r_dcnt + 3'h1;
        end
      end
    end

    // request fields, msb first, one word per sixteen bits
    if (dv && st.r_in) begin
      next_st.r_crc  = crc_step(st.r_crc, db); // R1 R6 R16
      next_st.r_sreg = {st.r_sreg[14:0], db}; // R22
      if (st.r_bitn != tms_pkg::BITN_LIMIT) next_st.r_bitn = st.r_bitn + 16'h0001;
      if (st.r_bitn[3:0] == 4'hF) begin
        w = {st.r_sreg[14:0], db};
        k = st.r_bitn[15:4];
        if (k < tms_pkg::W_PARITY) next_st.r_par = st.r_par ^ w;
        blocked = !st.seq_done || st.seq_err || st.r_par_err || st.r_adr_err
                  || st.r_fmt_err || st.r_func != tms_pkg::FN_WRITE;
        if (k == tms_pkg::W_CTRL) begin
          next_st.r_term   = w[15:8];
          next_st.r_func   = w[7:4];
          next_st.r_seq    = w[3:0];
          next_st.seq_go   = 1'b1;
          next_st.seq_done = 1'b0;
          next_st.seq_err  = 1'b0;
        end else if (k == tms_pkg::W_START) begin
          next_st.r_start = w;
        end else if (k == tms_pkg::W_CSTART) begin
          if (w != ~st.r_start) next_st.r_adr_err = 1'b1;
        end else if (k == tms_pkg::W_CEND) begin
          next_st.r_end = ~w;
        end else if (k == tms_pkg::W_PARITY) begin
          if ((st.r_par ^ w) != 16'h0000) next_st.r_par_err = 1'b1; // R7 R14
        end else if (k == tms_pkg::W_DATA) begin
          next_st.r_hold = w;
          next_st.r_wptr = st.r_start;
        end else begin
          // the word held back is data; the newest may still be the CRC
          next_st.r_hold = w;
          if (k - tms_pkg::W_DATA_NEXT >= tms_pkg::MAX_WORDS[11:0]) begin
            next_st.r_fmt_err = 1'b1; // R15
          end else if (!blocked) begin // R25
            if (st.wr_pend && st.e_st != tms_pkg::E_DAT_WR) begin
              next_st.r_ovf_err = 1'b1;
            end else begin
              next_st.wr_pend = 1'b1;
              next_st.p_addr  = st.r_wptr;
              next_st.p_data  = st.r_hold;
              next_st.r_wptr  = st.r_wptr + 16'h0001;
            end
          end
        end
      end
    end

    // transmitter: flags, stuffed body, CRC
    if (tx_tick) begin
      case (st.t_mode)
        tms_pkg::T_FLAG: begin
          next_st.tx_data = tms_pkg::FLAG_PATTERN[3'h7 - st.t_fi]; // R9
          next_st.t_fi    = st.t_fi + 3'h1;
          if (st.t_fi == 3'h7 && q_out_valid) begin
            q_out_ready    = 1'b1;
            next_st.t_sreg = q_out_data[15:0];
            next_st.t_last = q_out_data[16];
            next_st.t_mode = tms_pkg::T_DATA;
            next_st.t_cnt  = 4'h0;
            next_st.t_ones = 3'h0;
            next_st.t_crc  = tms_pkg::CRC_INIT;
          end
        end
        tms_pkg::T_DATA, tms_pkg::T_CRC: begin
          if (st.t_ones == tms_pkg::STUFF_ONES) begin
            next_st.tx_data = 1'b0; // R20
            next_st.t_ones  = 3'h0;
          end else begin
            tb = st.t_sreg[15]; // R22
            next_st.tx_data = tb;
            next_st.t_ones  = tb ? st.t_ones + 3'h1 : 3'h0;
            next_st.t_sreg  = {st.t_sreg[14:0], 1'b0};
            next_st.t_cnt   = st.t_cnt + 4'h1;
            if (st.t_mode == tms_pkg::T_DATA) next_st.t_crc = crc_step(st.t_crc, tb); // R12
            if (st.t_cnt == 4'hF) begin
              if (st.t_mode == tms_pkg::T_CRC) begin
                next_st.t_mode = tms_pkg::T_END; // R18
              end else if (st.t_last) begin
                next_st.t_sreg = crc_step(st.t_crc, tb);
                next_st.t_mode = tms_pkg::T_CRC;
              end else if (q_out_valid) begin
                q_out_ready    = 1'b1;
                next_st.t_sreg = q_out_data[15:0];
                next_st.t_last = q_out_data[16];
              end else begin
                next_st.t_mode = tms_pkg::T_END;
              end
            end
          end
        end
        tms_pkg::T_END: begin
          // the zero is either a pending stuff bit or the flag's first bit
          next_st.tx_data = 1'b0;
          next_st.t_mode  = tms_pkg::T_FLAG;
          next_st.t_fi    = (st.t_ones == tms_pkg::STUFF_ONES) ? 3'h0 : 3'h1;
          next_st.t_ones  = 3'h0;
        end
        default: next_st.t_mode = tms_pkg::T_FLAG;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : tms_engine

/* File: test/tms_engine_assertions.sv */
// port checks of the engine
module tms_engine_assertions #(
  parameter logic [15:0] SEQ_BASE    = tms_pkg::SEQ_BASE_DEF,
  parameter logic [3:0]  RESP_ACCEPT = tms_pkg::RESP_ACC_DEF,
  parameter logic [3:0]  RESP_REJECT = tms_pkg::RESP_REJ_DEF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // link
  input  wire logic        tx_clk_pin,
  input  wire logic        tx_data,
  // memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        mem_ack,
  // status
  input  wire logic        msg_done,
  input  wire logic        msg_accepted
);
  logic [1:0] tck;
  logic [2:0] ones;
  logic [3:0] last_code;
  logic       seq_wr;

  assign seq_wr = mem_req && mem_ack && mem_we && mem_addr >= SEQ_BASE;

  // ones on the line, one sample per tx bit
  always_ff @(posedge clk) begin
    if (srst) begin
      tck       <= 2'h0;
      ones      <= 3'h0;
      last_code <= RESP_REJECT;
    end else begin
      tck <= {tck[0], tx_clk_pin};
      if (tck == 2'h1) ones <= tx_data ? (ones == 3'h7 ? ones : ones + 3'h1) : 3'h0;
      if (seq_wr) last_code <= mem_wdata[7:4];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_req_hold : assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
      && $stable(mem_wdata)) else $error("request moved before ack");
  a_done_pulse : assert property (msg_done |=> !msg_done)
    else $error("status pulse too long");
  a_acc_moves : assert property ($changed(msg_accepted) |-> msg_done)
    else $error("accept moved without status");
  a_no_seven : assert property (ones != 3'h7)
    else $error("seven ones sent");
  a_seq_owner : assert property (
    seq_wr |-> mem_wdata[15:8] == 8'(mem_addr - SEQ_BASE))
    else $error("sequence word terminal wrong");
  a_code_legal : assert property (
    seq_wr |-> mem_wdata[7:4] == RESP_ACCEPT || mem_wdata[7:4] == RESP_REJECT)
    else $error("stored response code unknown");
  a_done_code : assert property (
    msg_done |-> last_code == (msg_accepted ? RESP_ACCEPT : RESP_REJECT))
    else $error("status differs from stored response");
  a_seq_done : assert property (seq_wr |-> ##[0:1000] msg_done)
    else $error("no status after sequence store");
endmodule : tms_engine_assertions

bind tms_engine tms_engine_assertions #(
  .SEQ_BASE(SEQ_BASE), .RESP_ACCEPT(RESP_ACCEPT), .RESP_REJECT(RESP_REJECT)
) u_chk (
  .clk(clk), .srst(srst), .tx_clk_pin(tx_clk_pin), .tx_data(tx_data), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .msg_done(msg_done), .msg_accepted(msg_accepted)
);

/* File: test/tms_terminal.sv */
// remote terminal model
module tms_terminal (
  // link
  output logic        rx_clk_pin,
  output logic        rx_data_pin,
  output logic        tx_clk_pin,
  input  wire logic   tx_data,
  // decoded response
  output logic [15:0] hdr,
  output logic [15:0] rlen,
  output int          rsp_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] crc;
  logic [15:0] sh;
  int          ones;
  int          ones_t = 0;
  int          cnt = 0;

  initial begin
    rx_clk_pin  = 1'b0;
    rx_data_pin = 1'b0;
    tx_clk_pin  = 1'b0;
    rsp_cnt     = 0;
  end

  // free-running transmit clock
  always #250 tx_clk_pin = ~tx_clk_pin;

  task automatic bit_out(input logic b);
    rx_data_pin = b;
    #250 rx_clk_pin = 1'b1;
    #250 rx_clk_pin = 1'b0;
  endtask : bit_out

  task automatic flag_out;
    for (int i = 7; i >= 0; i--) bit_out(tms_pkg::FLAG_PATTERN[i]);
  endtask : flag_out

  task automatic word_out(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      crc = {crc[14:0], 1'b0} ^ ((w[i] ^ crc[15]) ? tms_pkg::CRC_POLY_DEF : 16'h0000);
      bit_out(w[i]);
      ones = w[i] ? ones + 1 : 0;
      if (ones == 5) begin
        bit_out(1'b0);
        ones = 0;
      end
    end
  endtask : word_out

  // err[0] spoils parity, err[1] crc
  task automatic send(input logic [15:0] w0, st, en, input int n, input logic [1:0] err);
    logic [15:0] c;
    ones = 0;
    crc  = 16'h0000;
    flag_out();
    flag_out();
    word_out(w0);
    word_out(st);
    word_out(~st);
    word_out(~en);
    word_out(w0 ^ st ^ ~st ^ ~en ^ {15'h0, err[0]});
    for (int i = 0; i < n; i++) word_out(16'hA500 + 16'(i));
    c = crc ^ {15'h0, err[1]};
    word_out(c);
    flag_out();
  endtask : send

  // destuff; closing flag adds 7 bits
  always @(posedge tx_clk_pin) begin
    if (ones_t == 6 && !tx_data) begin
      if (cnt > 8) begin
        hdr  = sh;
        rlen = 16'(cnt - 7);
        rsp_cnt++;
      end
      cnt    = 0;
      ones_t = 0;
    end else if (ones_t == 5 && !tx_data) ones_t = 0;
    else begin
      ones_t = tx_data ? ones_t + 1 : 0;
      if (cnt < 16) sh = {sh[14:0], tx_data};
      cnt++;
    end
  end
endmodule : tms_terminal

/* File: test/tms_engine_tb.sv */
// bench of the engine
module tms_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        mem_ack = 1'b0;
  logic        tx_data, mem_req, mem_we, msg_done, msg_accepted;
  logic        rx_clk_pin, rx_data_pin, tx_clk_pin;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, hdr, rlen;
  logic [15:0] mem [0:65535];
  int          rsp_cnt;
  int          err_count = 0;
  int          n_compared = 0;
  int          rd_cnt = 0;
  int          cyc = 0;

  always #25 clk = ~clk;
  assign mem_rdata = mem[mem_addr];

  // zero-wait memory, cycle ceiling
  always @(posedge clk) begin
    cyc     <= cyc + 1;
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && mem_ack && mem_we) mem[mem_addr] <= mem_wdata;
    if (mem_req && mem_ack && !mem_we) rd_cnt <= rd_cnt + 1;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end

  tms_engine dut (
    .clk(clk), .srst(srst), .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin),
    .tx_clk_pin(tx_clk_pin), .tx_data(tx_data), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .msg_done(msg_done), .msg_accepted(msg_accepted)
  );

  tms_terminal u_term (
    .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin), .tx_clk_pin(tx_clk_pin),
    .tx_data(tx_data), .hdr(hdr), .rlen(rlen), .rsp_cnt(rsp_cnt)
  );

  task automatic check(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("compared %0d bad %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic run(input logic [3:0] fn, sq, input logic [15:0] st, en, input int n,
                     input logic [1:0] err);
    int k = rsp_cnt;
    rd_cnt = 0;
    u_term.send({8'h3C, fn, sq}, st, en, n, err);
    for (int i = 0; i < 8000 && rsp_cnt == k; i++) @(posedge clk);
    check(16'(rsp_cnt - k), 16'h0001);
  endtask : run

  task automatic s_read_ok;
    run(tms_pkg::FN_READ, 4'h0, 16'h0010, 16'h0011, 0, 2'h0);
    check(16'(msg_accepted), 16'h0001);
    check(hdr, {8'h3C, tms_pkg::RESP_ACC_DEF, 4'h0});
    check(rlen, 16'h0040);
    check(16'(rd_cnt), 16'h0003);
    check(mem[16'hFF3C], 16'h3C01);
  endtask : s_read_ok

  task automatic s_write_ok;
    run(tms_pkg::FN_WRITE, 4'h1, 16'h0020, 16'h0021, 2, 2'h0);
    check(16'(msg_accepted), 16'h0001);
    check(hdr, {8'h3C, tms_pkg::RESP_ACC_DEF, 4'h1});
    check(rlen, 16'h0020);
    check(mem[16'h0020], 16'hA500);
    check(mem[16'h0021], 16'hA501);
    check(mem[16'hFF3C], 16'h3C02);
  endtask : s_write_ok

  task automatic s_seq_err;
    run(tms_pkg::FN_READ, 4'h7, 16'h0010, 16'h0011, 0, 2'h0);
    check(16'(msg_accepted), 16'h0000);
    check(hdr, {8'h3C, tms_pkg::RESP_REJ_DEF, 4'h7});
    check(rlen, 16'h0020);
    check(16'(rd_cnt), 16'h0001);
    check(mem[16'hFF3C], 16'h3CF2);
  endtask : s_seq_err

  task automatic s_par_err;
    run(tms_pkg::FN_WRITE, 4'h2, 16'h0030, 16'h0030, 1, 2'h1);
    check(16'(msg_accepted), 16'h0000);
    check(mem[16'h0030], 16'h0030);
  endtask : s_par_err

  task automatic s_crc_err;
    run(tms_pkg::FN_READ, 4'h2, 16'h0010, 16'h0011, 0, 2'h2);
    check(16'(msg_accepted), 16'h0000);
    check(16'(rd_cnt), 16'h0001);
    check(mem[16'hFF3C], 16'h3CF2);
  endtask : s_crc_err

  task automatic s_reset;
    run(tms_pkg::FN_RESET, 4'h9, 16'h0000, 16'h0000, 0, 2'h0);
    check(16'(msg_accepted), 16'h0001);
    check(rlen, 16'h0020);
    check(mem[16'hFF3C], 16'h3C00);
  endtask : s_reset

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 16'(i);
    mem[16'hFF3C] = 16'h3C00;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    s_read_ok();
    s_write_ok();
    s_seq_err();
    s_par_err();
    s_crc_err();
    s_reset();
    summarize();
  end
endmodule : tms_engine_tb
